/* core/cscc_alu_flags.v */
// flag generation from an alu result, add or subtract, byte or word
`timescale 1ns/10ps
`include "cscc_regs.vh"

module cscc_alu_flags (
    // operands and result
    input  wire [15:0] opa_i,
    input  wire [15:0] opb_i,
    input  wire [15:0] res_i,
    input  wire        byte_i,
    input  wire        sub_i,
    input  wire        carry_out_i,
    // derived flags
    output wire        half_o,
    output wire        neg_o,
    output wire        wrap_o,
    output wire        zero_o,
    output wire        carry_o
);

    wire [15:0] opb_eff;
    wire        sa;
    wire        sb;
    wire        sr;

    // subtraction works on the complemented operand so carry means no borrow
    assign opb_eff = sub_i ? ~opb_i : opb_i;
    // carry into bit n is a^b^r at bit n
    assign half_o  = byte_i ? (opa_i[4] ^ opb_eff[4] ^ res_i[4])
                            : (opa_i[8] ^ opb_eff[8] ^ res_i[8]);
    assign sa      = byte_i ? opa_i[7]   : opa_i[15];
    assign sb      = byte_i ? opb_eff[7] : opb_eff[15];
    assign sr      = byte_i ? res_i[7]   : res_i[15];
    assign neg_o   = sr;
    // sign flips wrongly only when both inputs agree and result disagrees
    assign wrap_o  = (sa == sb) && (sr != sa);
    assign zero_o  = byte_i ? (res_i[7:0] == 8'h00) : (res_i == 16'h0000);
    assign carry_o = carry_out_i;

endmodule

/* core/cscc_regs.vh */
// register offsets, bit positions, reset values and timing counts for the cpu status block
`ifndef CSCC_REGS_VH
`define CSCC_REGS_VH

// byte offsets on the register bus
`define CSCC_OFF_FLAGS      4'h0
`define CSCC_OFF_SETTINGS   4'h4
`define CSCC_OFF_PAGE       4'h8
`define CSCC_OFF_IRQCTL     4'hC

// cpu_flags bit positions
`define CSCC_FL_CARRY       0
`define CSCC_FL_ZERO        1
`define CSCC_FL_WRAP        2
`define CSCC_FL_NEG         3
`define CSCC_FL_LOOP        4
`define CSCC_FL_PRIO_LO     5
`define CSCC_FL_PRIO_HI     7
`define CSCC_FL_HALF        8

// core_settings bit positions
`define CSCC_CS_WINDOW      2
`define CSCC_CS_PRIO_TOP    3

// irq_global_ctrl bit position
`define CSCC_IC_NEST_DIS    15

// reset values
`define CSCC_FLAGS_RST      9'h000
`define CSCC_SETTINGS_RST   2'h0
`define CSCC_PAGE_RST       8'h00

// divide timing in instruction cycles
`define CSCC_DIV_CYCLES     5'h13

// axi response codes
`define CSCC_RESP_OKAY      2'h0
`define CSCC_RESP_SLVERR    2'h2

`endif

/* core/cscc_top.v */
// cpu status and core control register block with axi4-lite slave
//
// Summary of operation
// - unimplemented bits of flags and settings read zero, writes ignored
// - half carry at bit 8 from carry out of bit 3 or bit 7
// - bits 7..5 hold priority level low, 111 blocks user interrupts
// - top bit plus low field form level; top bit one blocks interrupts
// - priority low field read-only when nesting disable set
// - loop active flag bit 4 read-only, one while repeat runs
// - negative flag bit 3 follows result sign
// - signed wrap flag bit 2 on two's-complement overflow
// - zero flag cleared by non-zero result, set stays until cleared
// - carry flag bit 0 from carry out of msb
// - priority top set by hardware above 7, software may only clear
// - settings bit 2 enables program window in data space
// - upper 32 kbytes routed to program page chosen by 8-bit page
// - interrupts may be taken inside a repeat loop, loop flag saved and cleared, restored on return
// - divide inside repeat completes in 19 cycles, interruptible
// - subtract uses carry and half carry as inverted borrows
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`include "cscc_regs.vh"

module cscc_top #(
    parameter PAGE_W = 8
) (
    // clock, reset, enable
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    input  wire        ce_i,
    // axi4-lite write address
    input  wire [3:0]  s_axi_awaddr_i,
    input  wire        s_axi_awvalid_i,
    output reg         s_axi_awready_o,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata_i,
    input  wire [3:0]  s_axi_wstrb_i,
    input  wire        s_axi_wvalid_i,
    output reg         s_axi_wready_o,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp_o,
    output reg         s_axi_bvalid_o,
    input  wire        s_axi_bready_i,
    // axi4-lite read address
    input  wire [3:0]  s_axi_araddr_i,
    input  wire        s_axi_arvalid_i,
    output reg         s_axi_arready_o,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata_o,
    output reg  [1:0]  s_axi_rresp_o,
    output reg         s_axi_rvalid_o,
    input  wire        s_axi_rready_i,
    // alu result and flag update enables
    input  wire        alu_valid_i,
    input  wire [15:0] alu_opa_i,
    input  wire [15:0] alu_opb_i,
    input  wire [15:0] alu_res_i,
    input  wire        alu_carry_i,
    input  wire        alu_byte_i,
    input  wire        alu_sub_i,
    input  wire [4:0]  alu_upd_i,
    // sequencer: repeat loop and divide
    input  wire        repeat_start_i,
    input  wire        repeat_end_i,
    input  wire        div_start_i,
    input  wire        irq_take_i,
    input  wire        irq_return_i,
    // interrupt controller priority update
    input  wire        prio_load_i,
    input  wire [3:0]  prio_level_i,
    // data space address for the program window
    input  wire [15:0] daddr_i,
    // status outputs
    output reg  [3:0]  cpu_priority_o,
    output reg         user_irq_block_o,
    output reg         loop_active_o,
    output reg         div_busy_o,
    output reg         div_done_o,
    output reg         window_hit_o,
    output reg  [23:0] window_addr_o
);

    ////////////////////////////////////////////////////////////////////////
    // state
    reg  [8:0]        flags_reg;
    reg  [1:0]        settings_reg;
    reg  [PAGE_W-1:0] page_reg;
    reg               nest_dis_reg;
    reg  [4:0]        div_cnt_reg;
    reg               div_susp_reg;
    reg               loop_saved_reg;
    reg  [3:0]        aw_addr_reg;
    reg  [31:0]       w_data_reg;
    reg  [3:0]        w_strb_reg;
    reg               aw_have_reg;
    reg               w_have_reg;

    wire              f_half;
    wire              f_neg;
    wire              f_wrap;
    wire              f_zero;
    wire              f_carry;
    wire              win_hit;
    wire [23:0]       win_addr;
    wire              wr_go;
    wire              wr_flags;
    wire              wr_sett;
    wire              rd_go;

    ////////////////////////////////////////////////////////////////////////
    // flag generation and window mapping
    cscc_alu_flags u_flags (
        .opa_i       (alu_opa_i),
        .opb_i       (alu_opb_i),
        .res_i       (alu_res_i),
        .byte_i      (alu_byte_i),
        .sub_i       (alu_sub_i),
        .carry_out_i (alu_carry_i),
        .half_o      (f_half),
        .neg_o       (f_neg),
        .wrap_o      (f_wrap),
        .zero_o      (f_zero),
        .carry_o     (f_carry)
    );

    cscc_window_map #(.PAGE_W(PAGE_W)) u_win (
        .daddr_i  (daddr_i),
        .enable_i (settings_reg[0]),
        .page_i   (page_reg),
        .hit_o    (win_hit),
        .paddr_o  (win_addr)
    );

    // merge a 16-bit register with write strobes
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] wd;
        input [3:0]  st;
        begin
            merge16[7:0]  = st[0] ? wd[7:0]  : old[7:0];
            merge16[15:8] = st[1] ? wd[15:8] : old[15:8];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // axi write channel capture; address and data accepted in either order
    assign wr_go    = aw_have_reg & w_have_reg & ~s_axi_bvalid_o;
    assign wr_flags = wr_go & (aw_addr_reg == `CSCC_OFF_FLAGS);
    assign wr_sett  = wr_go & (aw_addr_reg == `CSCC_OFF_SETTINGS);
    assign rd_go    = s_axi_arvalid_i & s_axi_arready_o;

    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            aw_have_reg     <= 1'b0;
            w_have_reg      <= 1'b0;
            aw_addr_reg     <= 4'h0;
            w_data_reg      <= 32'h0000_0000;
            w_strb_reg      <= 4'h0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= `CSCC_RESP_OKAY;
        end else if (ce_i) begin
            s_axi_awready_o <= ~aw_have_reg & ~s_axi_awready_o & ~s_axi_bvalid_o;
            s_axi_wready_o  <= ~w_have_reg & ~s_axi_wready_o & ~s_axi_bvalid_o;
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_have_reg     <= 1'b1;
                aw_addr_reg     <= {s_axi_awaddr_i[3:2], 2'b00};
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_have_reg     <= 1'b1;
                w_data_reg     <= s_axi_wdata_i;
                w_strb_reg     <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (wr_go) begin
                aw_have_reg    <= 1'b0;
                w_have_reg     <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= `CSCC_RESP_OKAY;
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi read channel; one cycle from address to data
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0000_0000;
            s_axi_rresp_o   <= `CSCC_RESP_OKAY;
        end else if (ce_i) begin
            s_axi_arready_o <= ~s_axi_arready_o & ~s_axi_rvalid_o;
            if (rd_go) begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o  <= 1'b1;
                s_axi_rresp_o   <= `CSCC_RESP_OKAY;
                // upper bits always zero
                case ({s_axi_araddr_i[3:2], 2'b00})
                    `CSCC_OFF_FLAGS:    s_axi_rdata_o <= {23'h000000, flags_reg};
                    `CSCC_OFF_SETTINGS: s_axi_rdata_o <= {28'h0000000, settings_reg, 2'b00};
                    `CSCC_OFF_PAGE:     s_axi_rdata_o <= {{(32-PAGE_W){1'b0}}, page_reg};
                    `CSCC_OFF_IRQCTL:   s_axi_rdata_o <= {16'h0000, nest_dis_reg, 15'h0000};
                    default:            s_axi_rdata_o <= 32'h0000_0000;
                endcase
            end else if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags, settings, page; hardware updates win over software writes
    always @(posedge clk_sys_i) begin : regs_p
        reg [15:0] wv;
        wv = 16'h0000;
        if (!rst_n_i) begin
            flags_reg      <= `CSCC_FLAGS_RST;
            settings_reg   <= `CSCC_SETTINGS_RST;
            page_reg       <= {PAGE_W{1'b0}};
            nest_dis_reg   <= 1'b0;
            loop_saved_reg <= 1'b0;
        end else if (ce_i) begin
            // software writes, only implemented bits land
            if (wr_flags) begin
                wv = merge16({7'h00, flags_reg}, w_data_reg, w_strb_reg);
                flags_reg[8]   <= wv[8];
                flags_reg[3:0] <= wv[3:0];
                if (!nest_dis_reg)
                    flags_reg[7:5] <= wv[7:5];
            end
            if (wr_sett) begin
                wv = merge16({12'h000, settings_reg, 2'b00}, w_data_reg, w_strb_reg);
                settings_reg[0] <= wv[`CSCC_CS_WINDOW];
                if (!wv[`CSCC_CS_PRIO_TOP])
                    settings_reg[1] <= 1'b0;
            end
            if (wr_go && aw_addr_reg == `CSCC_OFF_PAGE)
                page_reg <= w_data_reg[PAGE_W-1:0];
            if (wr_go && aw_addr_reg == `CSCC_OFF_IRQCTL && w_strb_reg[1])
                nest_dis_reg <= w_data_reg[`CSCC_IC_NEST_DIS];
            // alu flags, only those the instruction affects
            if (alu_valid_i) begin
                if (alu_upd_i[4]) flags_reg[8] <= f_half;
                if (alu_upd_i[3]) flags_reg[3] <= f_neg;
                if (alu_upd_i[2]) flags_reg[2] <= f_wrap;
                // zero is sticky: only a non-zero result clears it
                if (alu_upd_i[1] && !f_zero) flags_reg[1] <= 1'b0;
                if (alu_upd_i[0]) flags_reg[0] <= f_carry;
            end
            // priority from the interrupt controller, top bit set above 7
            if (prio_load_i) begin
                flags_reg[7:5] <= prio_level_i[2:0];
                if (prio_level_i[3])
                    settings_reg[1] <= 1'b1;
            end
            // loop flag: saved across an interrupt, restored on return
            if (irq_take_i) begin
                loop_saved_reg <= flags_reg[4];
                flags_reg[4]   <= 1'b0;
            end else if (irq_return_i) begin
                flags_reg[4] <= loop_saved_reg;
            end else if (repeat_start_i) begin
                flags_reg[4] <= 1'b1;
            end else if (repeat_end_i) begin
                flags_reg[4] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // divide iteration counter, frozen while an interrupt is serviced
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            div_cnt_reg  <= 5'h00;
            div_susp_reg <= 1'b0;
            div_busy_o   <= 1'b0;
            div_done_o   <= 1'b0;
        end else if (ce_i) begin
            div_done_o <= 1'b0;
            if (irq_take_i && div_busy_o)
                div_susp_reg <= 1'b1;
            else if (irq_return_i)
                div_susp_reg <= 1'b0;
            if (div_start_i && !div_busy_o) begin
                div_cnt_reg <= `CSCC_DIV_CYCLES - 5'h01;
                div_busy_o  <= 1'b1;
            end else if (div_busy_o && !div_susp_reg && !irq_take_i) begin
                if (div_cnt_reg == 5'h01) begin
                    div_busy_o <= 1'b0;
                    div_done_o <= 1'b1;
                end
                div_cnt_reg <= div_cnt_reg - 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered status outputs
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cpu_priority_o   <= 4'h0;
            user_irq_block_o <= 1'b0;
            loop_active_o    <= 1'b0;
            window_hit_o     <= 1'b0;
            window_addr_o    <= 24'h000000;
        end else if (ce_i) begin
            cpu_priority_o   <= {settings_reg[1], flags_reg[7:5]};
            user_irq_block_o <= settings_reg[1] | (flags_reg[7:5] == 3'h7);
            loop_active_o    <= flags_reg[4];
            window_hit_o     <= win_hit;
            window_addr_o    <= win_addr;
        end
    end

endmodule

/* core/cscc_window_map.v */
// program window address mapping for the upper half of data space
`timescale 1ns/10ps
`include "cscc_regs.vh"

module cscc_window_map #(
    parameter PAGE_W = 8
) (
    // data space address and controls
    input  wire [15:0]       daddr_i,
    input  wire              enable_i,
    input  wire [PAGE_W-1:0] page_i,
    // program space routing
    output wire              hit_o,
    output wire [23:0]       paddr_o
);

    // upper 32 kbytes map to a 16k word page; byte address into 24-bit space
    assign hit_o   = enable_i & daddr_i[15];
    assign paddr_o = {1'b0, page_i, daddr_i[14:0]};

endmodule

/* testbench/cscc_alu_model.sv */
// behavioural alu datapath that feeds results to the status block
`timescale 1ns/10ps
module cscc_alu_model (
    // operands and mode
    input  wire [15:0] opa_i,
    input  wire [15:0] opb_i,
    input  wire        byte_i,
    input  wire        sub_i,
    // result and carry out of the msb
    output wire [15:0] res_o,
    output wire        carry_o
);
    wire [16:0] wsum;
    wire [8:0]  bsum;
    // subtract adds the complement plus one, so carry reads as no borrow
    assign wsum = {1'b0, opa_i} + {1'b0, sub_i ? ~opb_i : opb_i} + {16'h0000, sub_i};
    assign bsum = {1'b0, opa_i[7:0]} + {1'b0, sub_i ? ~opb_i[7:0] : opb_i[7:0]} + {8'h00, sub_i};
    // byte results leave the upper byte clear
    assign res_o   = byte_i ? {8'h00, bsum[7:0]} : wsum[15:0];
    assign carry_o = byte_i ? bsum[8] : wsum[16];
endmodule

/* testbench/cscc_chk_assertions.sv */
// concurrent checks on the ports of the cpu status block
`timescale 1ns/10ps
module cscc_chk (
    // clock and control
    input wire        clk_sys_i,
    input wire        rst_n_i,
    input wire        ce_i,
    // read channel
    input wire [3:0]  s_axi_araddr_i,
    input wire        s_axi_arvalid_i,
    input wire        s_axi_arready_o,
    input wire [31:0] s_axi_rdata_o,
    input wire        s_axi_rvalid_o,
    // core side
    input wire        repeat_start_i,
    input wire        repeat_end_i,
    input wire        div_start_i,
    input wire        irq_take_i,
    input wire        irq_return_i,
    input wire        prio_load_i,
    input wire [3:0]  prio_level_i,
    input wire [15:0] daddr_i,
    // status
    input wire [3:0]  cpu_priority_o,
    input wire        user_irq_block_o,
    input wire        loop_active_o,
    input wire        div_busy_o,
    input wire        div_done_o,
    input wire        window_hit_o,
    input wire [23:0] window_addr_o
);
    reg [3:0] rd_a_reg;
    reg [5:0] busy_cnt_reg;
    // read address in flight and busy length; freeze only lengthens the count
    always @(posedge clk_sys_i) begin
        if (s_axi_arvalid_i && s_axi_arready_o) rd_a_reg <= s_axi_araddr_i;
        busy_cnt_reg <= div_busy_o ? busy_cnt_reg + 6'h01 : 6'h00;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    AST_BLOCK: assert property (user_irq_block_o == (&cpu_priority_o[2:0] | cpu_priority_o[3]))
        else $error("irq block does not follow priority");
    // status outputs trail the internal registers by one enabled cycle
    AST_PRIO: assert property (prio_load_i && ce_i ##1 ce_i |=>
        cpu_priority_o[2:0] == $past(prio_level_i[2:0], 2) && (cpu_priority_o[3] || !$past(prio_level_i[3], 2)))
        else $error("loaded priority not shown");
    AST_LOOP_ON: assert property (repeat_start_i && ce_i && !repeat_end_i && !irq_return_i && !irq_take_i
        ##1 ce_i |=> loop_active_o)
        else $error("loop flag not raised");
    AST_LOOP_OFF: assert property (repeat_end_i && ce_i && !repeat_start_i && !irq_return_i
        ##1 ce_i |=> !loop_active_o)
        else $error("loop flag not dropped");
    AST_DIV_ON: assert property (div_start_i && ce_i && !div_busy_o && !irq_take_i |=> div_busy_o [*8])
        else $error("divide busy missing");
    AST_DIV_LEN: assert property (div_done_o |-> busy_cnt_reg >= 6'h12)
        else $error("divide finished early");
    AST_DONE: assert property (div_done_o |-> $past(div_busy_o))
        else $error("done without busy");
    AST_WIN: assert property ($past(ce_i) && window_hit_o |-> $past(daddr_i[15]) && !window_addr_o[23] && window_addr_o[14:0] == $past(daddr_i[14:0]))
        else $error("window address wrong");
    AST_RST: assert property (disable iff (1'b0) !rst_n_i && ce_i |=> cpu_priority_o == 4'h0 && !loop_active_o && !div_busy_o && !window_hit_o)
        else $error("outputs not cleared by reset");
    AST_RD_FL: assert property (s_axi_rvalid_o && rd_a_reg == 4'h0 |-> s_axi_rdata_o[31:9] == 23'h000000)
        else $error("flags unused bits not zero");
    AST_RD_CS: assert property (s_axi_rvalid_o && rd_a_reg == 4'h4 |-> s_axi_rdata_o[31:4] == 28'h0000000 && s_axi_rdata_o[1:0] == 2'h0)
        else $error("settings unused bits not zero");
    // main scenarios reached
    cover property (div_done_o);
    cover property (window_hit_o);
    cover property (irq_take_i && div_busy_o);
endmodule
bind cscc_top cscc_chk u_cscc_chk (.*);

/* testbench/test_cpu_status_core_control.sv */
// self-checking bench for the cpu status block
`timescale 1ns/10ps
`include "cscc_regs.vh"
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin err_count = err_count + 1; $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module test_cpu_status_core_control;
    logic        clk_sys_i, rst_n_i, ce_i;
    logic [3:0]  s_axi_awaddr_i, s_axi_wstrb_i, s_axi_araddr_i, prio_level_i, cpu_priority_o;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
    logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
    logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic        alu_valid_i, alu_carry_i, alu_byte_i, alu_sub_i;
    logic [15:0] alu_opa_i, alu_opb_i, alu_res_i, daddr_i;
    logic [4:0]  alu_upd_i;
    logic        repeat_start_i, repeat_end_i, div_start_i, irq_take_i, irq_return_i, prio_load_i;
    logic        user_irq_block_o, loop_active_o, div_busy_o, div_done_o, window_hit_o;
    logic [23:0] window_addr_o;
    integer      err_count, compares, n, d;
    integer      cyc = 0;
    cscc_top u_cscc_top (.*);
    cscc_alu_model u_cscc_alu_model (.opa_i(alu_opa_i), .opb_i(alu_opb_i), .byte_i(alu_byte_i), .sub_i(alu_sub_i),
                                     .res_o(alu_res_i), .carry_o(alu_carry_i));
    // 100 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            report_and_stop();
        end
    end
    task report_and_stop();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task tick(input integer k);
        repeat (k) @(posedge clk_sys_i);
    endtask
    // write: both channels offered together, each released once taken
    task axw(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        {s_axi_awaddr_i, s_axi_wdata_i, s_axi_wstrb_i} <= {a, v, 4'h3};
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (s_axi_bvalid_o !== 1'b1);
        `CHK(s_axi_bresp_o, `CSCC_RESP_OKAY)
        s_axi_bready_i <= 1'b0;
    endtask
    task axr(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_sys_i);
        {s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} <= {a, 2'h3};
        do begin
            @(posedge clk_sys_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (s_axi_rvalid_o !== 1'b1);
        v = s_axi_rdata_o;
        `CHK(s_axi_rresp_o, `CSCC_RESP_OKAY)
        s_axi_rready_i <= 1'b0;
    endtask
    // one alu result, then read the flags back
    task flag_case(input logic [15:0] a, b, input logic bt, sb, input logic [4:0] up, input logic [8:0] ex);
        @(posedge clk_sys_i);
        {alu_opa_i, alu_opb_i, alu_byte_i, alu_sub_i, alu_upd_i, alu_valid_i} <= {a, b, bt, sb, up, 1'b1};
        @(posedge clk_sys_i);
        alu_valid_i <= 1'b0;
        axr(`CSCC_OFF_FLAGS, rd);
        `CHK(rd, {23'h000000, ex})
    endtask
    task t_reset();
        axr(`CSCC_OFF_FLAGS, rd);
        `CHK(rd, 32'h00000000)
        axr(`CSCC_OFF_SETTINGS, rd);
        `CHK(rd, 32'h00000000)
        axr(`CSCC_OFF_PAGE, rd);
        `CHK(rd, 32'h00000000)
    endtask
    task t_flags();
        axw(`CSCC_OFF_FLAGS, 32'h00000002);
        axr(`CSCC_OFF_FLAGS, rd);
        `CHK(rd, 32'h00000002)
        flag_case(16'hFFFF, 16'h0001, 1'b0, 1'b0, 5'h1F, 9'h103);
        flag_case(16'h7FFF, 16'h0001, 1'b0, 1'b0, 5'h1F, 9'h10C);
        flag_case(16'h0000, 16'h0001, 1'b0, 1'b1, 5'h1F, 9'h008);
        flag_case(16'h0005, 16'h0003, 1'b0, 1'b1, 5'h1F, 9'h101);
        flag_case(16'h000F, 16'h0001, 1'b1, 1'b0, 5'h1F, 9'h100);
        flag_case(16'hFFFF, 16'h0001, 1'b0, 1'b0, 5'h01, 9'h101);
    endtask
    task t_prio();
        // outputs follow a register write one edge after the response
        axw(`CSCC_OFF_FLAGS, 32'h000000E0);
        tick(1);
        `CHK({user_irq_block_o, cpu_priority_o}, 5'h17)
        axw(`CSCC_OFF_FLAGS, 32'h00000040);
        tick(1);
        `CHK({user_irq_block_o, cpu_priority_o}, 5'h02)
        @(posedge clk_sys_i);
        {prio_load_i, prio_level_i} <= 5'h1A;
        @(posedge clk_sys_i);
        prio_load_i <= 1'b0;
        tick(2);
        `CHK({user_irq_block_o, cpu_priority_o}, 5'h1A)
        axr(`CSCC_OFF_SETTINGS, rd);
        `CHK(rd, 32'h00000008)
        axw(`CSCC_OFF_SETTINGS, 32'h0000000C);
        axr(`CSCC_OFF_SETTINGS, rd);
        `CHK(rd, 32'h0000000C)
        axw(`CSCC_OFF_SETTINGS, 32'h0000FFF4);
        axr(`CSCC_OFF_SETTINGS, rd);
        `CHK(rd, 32'h00000004)
        `CHK(cpu_priority_o, 4'h2)
        axw(`CSCC_OFF_IRQCTL, 32'h00008000);
        axw(`CSCC_OFF_FLAGS, 32'hFFFF00E3);
        axr(`CSCC_OFF_FLAGS, rd);
        `CHK(rd, 32'h00000043)
        axw(`CSCC_OFF_IRQCTL, 32'h00000000);
        axw(`CSCC_OFF_FLAGS, 32'h00000000);
        tick(1);
        `CHK(cpu_priority_o, 4'h0)
    endtask
    task t_window();
        axw(`CSCC_OFF_PAGE, 32'h000000A5);
        daddr_i <= 16'h8123;
        tick(2);
        `CHK({window_hit_o, window_addr_o}, {1'b1, 1'b0, 8'hA5, 15'h0123})
        // enable low freezes the mapped output
        ce_i <= 1'b0;
        daddr_i <= 16'h1234;
        tick(2);
        `CHK(window_hit_o, 1'b1)
        ce_i <= 1'b1;
        tick(2);
        `CHK(window_hit_o, 1'b0)
        axw(`CSCC_OFF_SETTINGS, 32'h00000000);
        daddr_i <= 16'h8123;
        tick(2);
        `CHK(window_hit_o, 1'b0)
    endtask
    task t_loop_div();
        repeat_start_i <= 1'b1;
        @(posedge clk_sys_i);
        repeat_start_i <= 1'b0;
        tick(2);
        `CHK(loop_active_o, 1'b1)
        axw(`CSCC_OFF_FLAGS, 32'h00000000);
        axr(`CSCC_OFF_FLAGS, rd);
        `CHK(rd, 32'h00000010)
        // second start mid-run must be ignored
        div_start_i <= 1'b1;
        @(posedge clk_sys_i);
        div_start_i <= 1'b0;
        n = 0;
        d = 0;
        repeat (30) begin
            @(posedge clk_sys_i);
            if (div_busy_o === 1'b1) n = n + 1;
            if (div_done_o === 1'b1) d = d + 1;
            div_start_i <= (n == 9);
        end
        // busy stands for the cycles after the start cycle
        `CHK(n, `CSCC_DIV_CYCLES - 5'h01)
        `CHK(d, 1)
        @(posedge clk_sys_i);
        div_start_i <= 1'b1;
        @(posedge clk_sys_i);
        div_start_i <= 1'b0;
        tick(4);
        irq_take_i <= 1'b1;
        @(posedge clk_sys_i);
        irq_take_i <= 1'b0;
        tick(25);
        `CHK(div_busy_o, 1'b1)
        irq_return_i <= 1'b1;
        @(posedge clk_sys_i);
        irq_return_i <= 1'b0;
        d = 0;
        repeat (30) begin
            @(posedge clk_sys_i);
            if (div_done_o === 1'b1) d = d + 1;
        end
        `CHK(d, 1)
        `CHK(loop_active_o, 1'b1)
        repeat_end_i <= 1'b1;
        @(posedge clk_sys_i);
        repeat_end_i <= 1'b0;
        tick(2);
        `CHK(loop_active_o, 1'b0)
    endtask
    task t_reset2();
        axw(`CSCC_OFF_FLAGS, 32'h000000E0);
        rst_n_i <= 1'b0;
        tick(3);
        rst_n_i <= 1'b1;
        tick(2);
        `CHK({user_irq_block_o, cpu_priority_o}, 5'h00)
        axr(`CSCC_OFF_FLAGS, rd);
        `CHK(rd, 32'h00000000)
    endtask
    initial begin
        err_count = 0;
        compares = 0;
        {s_axi_awaddr_i, s_axi_wdata_i, s_axi_wstrb_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
        {s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i, daddr_i} = '0;
        {alu_valid_i, alu_opa_i, alu_opb_i, alu_byte_i, alu_sub_i, alu_upd_i} = '0;
        {repeat_start_i, repeat_end_i, div_start_i, irq_take_i, irq_return_i, prio_load_i, prio_level_i} = '0;
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        tick(10);
        rst_n_i <= 1'b1;
        t_reset();
        t_flags();
        t_prio();
        t_window();
        t_loop_div();
        t_reset2();
        report_and_stop();
    end
endmodule
